// >>> upp_board.sv
`timescale 1ns/1ns
// board side of the user pins: external drivers, pull-ups and open lines
module upp_board (
  input wire logic clk,
  input wire logic [upp_pkg::PIN_COUNT-1:0] pin_out,
  input wire logic [upp_pkg::PIN_COUNT-1:0] pin_oe_n,
  input wire logic [upp_pkg::PIN_COUNT-1:0] pin_pullup,
  input wire logic [upp_pkg::PIN_COUNT-1:0] drv_en,
  input wire logic [upp_pkg::PIN_COUNT-1:0] drv_val,
  output logic [upp_pkg::PIN_COUNT-1:0] pin_level
);
  logic float_reg = 1'b0;

  // an open line toggles every clock, odd and even pins in opposite phase, so a read of it has no steady value
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  // device drive first, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < upp_pkg::PIN_COUNT; i++) begin
      if (!pin_oe_n[i]) begin
        pin_level[i] = pin_out[i];
      end else if (drv_en[i]) begin
        pin_level[i] = drv_val[i];
      end else if (pin_pullup[i]) begin
        pin_level[i] = 1'b1;
      end else begin
        pin_level[i] = float_reg ^ i[0];
      end
    end
  end
endmodule

// >>> upp_pkg.sv
package upp_pkg;
  // pin count and group split
  localparam int unsigned PIN_COUNT = 9;
  localparam int unsigned LOW_PINS = 8;
  localparam int unsigned ROUTE_REGS = 4;

  // special function register offsets
  localparam logic [7:0] ADDR_DATA_LOW = 8'h90;
  localparam logic [7:0] ADDR_DIR_LOW = 8'h91;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'ha0;
  localparam logic [7:0] ADDR_DIR_HIGH = 8'ha1;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;

  // routing registers in the extended space, four consecutive bytes
  localparam logic [15:0] ADDR_ROUTE_BASE = 16'hff90;
  localparam logic [15:0] ADDR_ROUTE_LAST = 16'hff93;

  // field layout of a routing register
  localparam int unsigned SEL_W = 3;
  localparam int unsigned SEL_EVEN_LSB = 0;
  localparam int unsigned SEL_ODD_LSB = 4;

  // interrupt type bits inside the timer control register
  localparam int unsigned TYPE0_BIT = 0;
  localparam int unsigned TYPE1_BIT = 2;

  // reset values
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;

  // selector codes
  localparam logic [2:0] SEL_NONE0 = 3'h0;
  localparam logic [2:0] SEL_NONE1 = 3'h1;
  localparam logic [2:0] SEL_TIMER0 = 3'h2;
  localparam logic [2:0] SEL_TIMER1 = 3'h3;
  localparam logic [2:0] SEL_IRQ0_HIGH = 3'h4;
  localparam logic [2:0] SEL_IRQ1_HIGH = 3'h5;
  localparam logic [2:0] SEL_IRQ0_LOW = 3'h6;
  localparam logic [2:0] SEL_IRQ1_LOW = 3'h7;

  // synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // internal resources fed from the pins
  typedef struct packed {
    logic timer0_gate_clock_in;
    logic timer1_gate_clock_in;
    logic ext_irq0;
    logic ext_irq1;
  } upp_res_t;

  // external interrupt type bits, 1 means edge
  typedef struct packed {
    logic ext_irq1_type;
    logic ext_irq0_type;
  } upp_irq_type_t;
endpackage

// >>> upp_port.sv
`timescale 1ns/1ns
module upp_port (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [15:0] xram_addr,
  input wire logic xram_we,
  input wire logic xram_re,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic [upp_pkg::PIN_COUNT-1:0] user_pin_in,
  output logic [upp_pkg::PIN_COUNT-1:0] user_pin_out,
  output logic [upp_pkg::PIN_COUNT-1:0] user_pin_oe_n,
  output logic [upp_pkg::PIN_COUNT-1:0] user_pin_pullup,
  output upp_pkg::upp_res_t resource_out,
  output upp_pkg::upp_irq_type_t irq_type_out
);
  localparam int unsigned NP = upp_pkg::PIN_COUNT;
  localparam int unsigned NL = upp_pkg::LOW_PINS;
  localparam int unsigned NR = upp_pkg::ROUTE_REGS;

  logic [NP-1:0] pin_sync;
  logic [7:0] data_low_reg, data_low_next;
  logic data_high_reg, data_high_next;
  logic [7:0] dir_low_reg, dir_low_next;
  logic dir_high_reg, dir_high_next;
  logic pull_low_reg, pull_low_next;
  logic pull_high_reg, pull_high_next;
  logic [7:0] route_reg [NR];
  logic [7:0] route_next [NR];
  upp_pkg::upp_irq_type_t irq_type_reg, irq_type_next;
  upp_pkg::upp_res_t res_reg, res_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] route_idx;
  logic route_hit;

  // selector of one low pin, even pins in the low field
  function automatic logic [2:0] pin_sel(input logic [7:0] r, input logic odd);
    logic [2:0] s;
    s = odd ? r[upp_pkg::SEL_ODD_LSB +: upp_pkg::SEL_W]
            : r[upp_pkg::SEL_EVEN_LSB +: upp_pkg::SEL_W];
    return s;
  endfunction

  // resource contribution of one pin
  function automatic upp_pkg::upp_res_t route_one(input logic [2:0] sel, input logic lvl);
    upp_pkg::upp_res_t r;
    r = '0;
    case (sel)
      upp_pkg::SEL_TIMER0: r.timer0_gate_clock_in = lvl;
      upp_pkg::SEL_TIMER1: r.timer1_gate_clock_in = lvl;
      upp_pkg::SEL_IRQ0_HIGH: r.ext_irq0 = lvl;
      upp_pkg::SEL_IRQ1_HIGH: r.ext_irq1 = lvl;
      upp_pkg::SEL_IRQ0_LOW: r.ext_irq0 = !lvl;
      upp_pkg::SEL_IRQ1_LOW: r.ext_irq1 = !lvl;
      default: r = '0;
    endcase
    return r;
  endfunction

  // routed pins see the pin itself, driven or not
  upp_sync #(
    .W(NP)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(user_pin_in),
    .q(pin_sync)
  );

  // extended-space decode for the routing bytes
  assign route_hit = (xram_addr >= upp_pkg::ADDR_ROUTE_BASE)
                   && (xram_addr <= upp_pkg::ADDR_ROUTE_LAST);
  assign route_idx = xram_addr[1:0];

  // register writes and read mux
  always_comb begin
    data_low_next = data_low_reg;
    data_high_next = data_high_reg;
    dir_low_next = dir_low_reg;
    dir_high_next = dir_high_reg;
    pull_low_next = pull_low_reg;
    pull_high_next = pull_high_reg;
    irq_type_next = irq_type_reg;
    rdata_next = rdata_reg;
    for (int i = 0; i < NR; i++) begin
      route_next[i] = route_reg[i];
    end
    if (sfr_we) begin
      unique case (sfr_addr)
        upp_pkg::ADDR_DATA_LOW: data_low_next = bus_wdata;
        upp_pkg::ADDR_DATA_HIGH: data_high_next = bus_wdata[0];
        upp_pkg::ADDR_DIR_LOW: begin
          dir_low_next = bus_wdata;
          pull_low_next = 1'b0;
        end
        upp_pkg::ADDR_DIR_HIGH: begin
          dir_high_next = bus_wdata[0];
          pull_high_next = 1'b0;
        end
        upp_pkg::ADDR_TIMER_CTRL: begin
          irq_type_next.ext_irq0_type = bus_wdata[upp_pkg::TYPE0_BIT];
          irq_type_next.ext_irq1_type = bus_wdata[upp_pkg::TYPE1_BIT];
        end
        default: ;
      endcase
    end
    // unused bits 3 and 7 are never stored
    if (xram_we && route_hit) begin
      route_next[route_idx] = bus_wdata & 8'h77;
    end
    if (sfr_re) begin
      unique case (sfr_addr)
        upp_pkg::ADDR_DATA_LOW: rdata_next = pin_sync[7:0];
        upp_pkg::ADDR_DATA_HIGH: rdata_next = {7'h00, pin_sync[NL]};
        upp_pkg::ADDR_DIR_LOW: rdata_next = dir_low_reg;
        upp_pkg::ADDR_DIR_HIGH: rdata_next = {7'h00, dir_high_reg};
        upp_pkg::ADDR_TIMER_CTRL: begin
          rdata_next = 8'h00;
          rdata_next[upp_pkg::TYPE0_BIT] = irq_type_reg.ext_irq0_type;
          rdata_next[upp_pkg::TYPE1_BIT] = irq_type_reg.ext_irq1_type;
        end
        default: rdata_next = 8'h00;
      endcase
    end else if (xram_re) begin
      rdata_next = route_hit ? route_reg[route_idx] : 8'h00;
    end
    if (!rstn) begin
      data_low_next = upp_pkg::DATA_RESET;
      data_high_next = 1'b1;
      dir_low_next = upp_pkg::DIR_RESET;
      dir_high_next = 1'b1;
      pull_low_next = 1'b1;
      pull_high_next = 1'b1;
      irq_type_next = upp_pkg::upp_irq_type_t'(2'b00);
      rdata_next = 8'h00;
      for (int i = 0; i < NR; i++) begin
        route_next[i] = upp_pkg::ROUTE_RESET;
      end
    end
  end

  // resource OR across the eight low pins, registered for clean outputs
  always_comb begin
    res_next = '0;
    for (int p = 0; p < NL; p++) begin
      res_next = res_next | route_one(pin_sel(route_reg[p/2], p[0]), pin_sync[p]);
    end
    if (!rstn) begin
      res_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    data_low_reg <= data_low_next;
    data_high_reg <= data_high_next;
    dir_low_reg <= dir_low_next;
    dir_high_reg <= dir_high_next;
    pull_low_reg <= pull_low_next;
    pull_high_reg <= pull_high_next;
    irq_type_reg <= irq_type_next;
    res_reg <= res_next;
    rdata_reg <= rdata_next;
    for (int i = 0; i < NR; i++) begin
      route_reg[i] <= route_next[i];
    end
  end

  // direction bit is the enable itself: 0 drives, 1 listens
  assign user_pin_out = {data_high_reg, data_low_reg};
  assign user_pin_oe_n = {dir_high_reg, dir_low_reg};
  assign user_pin_pullup = {pull_high_reg, {NL{pull_low_reg}}};
  assign resource_out = res_reg;
  // edge/level choice left to the interrupt logic downstream
  assign irq_type_out = irq_type_reg;
  assign bus_rdata = rdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // checks
  reset_input_a: assert property ($past(!rstn) |-> &user_pin_oe_n)
    else $error("pins not inputs after reset");
  dir_write_a: assert property (sfr_we && sfr_addr == upp_pkg::ADDR_DIR_LOW
    |=> user_pin_oe_n[7:0] == $past(bus_wdata))
    else $error("direction write not applied");
  pullup_drop_a: assert property (sfr_we && sfr_addr == upp_pkg::ADDR_DIR_HIGH
    |=> !user_pin_pullup[8] && $stable(user_pin_pullup[7:0]))
    else $error("pull-up release wrong");
  data_read_a: assert property (sfr_re && sfr_addr == upp_pkg::ADDR_DATA_HIGH
    |=> bus_rdata == {7'h00, $past(pin_sync[8])})
    else $error("pin 8 read wrong");
  timer0_route_a: assert property (pin_sel(route_reg[0], 1'b0) == upp_pkg::SEL_TIMER0
    && pin_sync[0] |=> resource_out.timer0_gate_clock_in)
    else $error("timer 0 route missing");
  irq0_invert_a: assert property (pin_sel(route_reg[1], 1'b1) == upp_pkg::SEL_IRQ0_LOW
    && !pin_sync[3] |=> resource_out.ext_irq0)
    else $error("inverted irq 0 missing");
  irq1_plain_a: assert property (pin_sel(route_reg[2], 1'b0) == upp_pkg::SEL_IRQ1_HIGH
    && pin_sync[4] |=> resource_out.ext_irq1)
    else $error("irq 1 route missing");
  none_route_a: assert property ((route_reg[0] & 8'h66) == 8'h00
    && (route_reg[1] & 8'h66) == 8'h00 && (route_reg[2] & 8'h66) == 8'h00
    && (route_reg[3] & 8'h66) == 8'h00 |=> resource_out == '0)
    else $error("resource seen with no route");
  type_bits_a: assert property (sfr_we && sfr_addr == upp_pkg::ADDR_TIMER_CTRL
    |=> irq_type_out == {$past(bus_wdata[2]), $past(bus_wdata[0])})
    else $error("type bits not stored");
  route_read_a: assert property (xram_we && route_hit ##1 xram_re && !sfr_re
    && xram_addr == $past(xram_addr) |=> bus_rdata == ($past(bus_wdata, 2) & 8'h77))
    else $error("routing readback wrong");
endmodule

// >>> upp_port_bench.sv
`timescale 1ns/1ns
// self-checking bench for the user pin port
module upp_port_bench;
  logic clk;
  logic rstn;
  logic [7:0] sfr_addr;
  logic sfr_we;
  logic sfr_re;
  logic [15:0] xram_addr;
  logic xram_we;
  logic xram_re;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic [8:0] pin_in;
  logic [8:0] pin_out;
  logic [8:0] pin_oe_n;
  logic [8:0] pin_pullup;
  logic [8:0] drv_en;
  logic [8:0] drv_val;
  upp_pkg::upp_res_t res;
  upp_pkg::upp_irq_type_t irq_type;
  logic [7:0] rd;
  int fail_count;
  int checked;

  upp_port i_upp_port (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_we(sfr_we),
    .sfr_re(sfr_re), .xram_addr(xram_addr), .xram_we(xram_we), .xram_re(xram_re),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .user_pin_in(pin_in),
    .user_pin_out(pin_out), .user_pin_oe_n(pin_oe_n), .user_pin_pullup(pin_pullup),
    .resource_out(res), .irq_type_out(irq_type));
  upp_board i_upp_board (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .drv_en(drv_en), .drv_val(drv_val), .pin_level(pin_in));

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one register cycle; strobes drop just after the taking edge
  task automatic bus(input logic x, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a[7:0];
    xram_addr = a;
    bus_wdata = d;
    {sfr_we, sfr_re, xram_we, xram_re} = {wr & !x, !wr & !x, wr & x, !wr & x};
    @(posedge clk);
    #1;
    {sfr_we, sfr_re, xram_we, xram_re} = 4'h0;
    rd = bus_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [3:0] route_exp(input logic [2:0] s, input logic p);
    route_exp = {s == 3'h2 && p, s == 3'h3 && p, (s == 3'h4 && p) || (s == 3'h6 && !p),
      (s == 3'h5 && p) || (s == 3'h7 && !p)};
  endfunction

  task automatic t_reset();
    chk(pin_oe_n, 9'h1ff);
    chk(pin_pullup, 9'h1ff);
    chk({res, irq_type}, 9'h000);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 1'b0, 16'hff90 + 16'(i), 8'h00);
      chk(rd, 9'h000);
    end
    bus(1'b0, 1'b0, 8'h90, 8'h00);
    chk(rd, 9'h0ff);
  endtask

  task automatic t_direction();
    bus(1'b0, 1'b1, 8'h91, 8'hfe);
    chk(pin_oe_n, 9'h1fe);
    chk(pin_pullup, 9'h100);
    bus(1'b0, 1'b1, 8'h90, 8'h00);
    chk(pin_out, 9'h100);
    drv_en = 9'h1fe;
    drv_val = 9'h0a5;
    cyc(3);
    bus(1'b0, 1'b0, 8'h90, 8'h00);
    chk(rd, 9'h0a4);
    bus(1'b0, 1'b1, 8'ha1, 8'h00);
    chk(pin_oe_n, 9'h0fe);
    chk(pin_pullup, 9'h000);
    bus(1'b0, 1'b1, 8'ha0, 8'hff);
    cyc(3);
    bus(1'b0, 1'b0, 8'ha0, 8'h00);
    chk(rd, 9'h001);
    bus(1'b0, 1'b0, 8'ha1, 8'h00);
    chk(rd, 9'h000);
  endtask

  // every selector code on an even slot, pin high and low
  task automatic t_route();
    for (int s = 0; s < 8; s++) begin
      for (int p = 0; p < 2; p++) begin
        bus(1'b1, 1'b1, 16'hff91, 8'(s));
        drv_val[2] = p[0];
        cyc(4);
        chk(res, route_exp(3'(s), p[0]));
      end
    end
    bus(1'b1, 1'b1, 16'hff91, 8'h22);
    drv_val[3:2] = 2'b10;
    cyc(4);
    chk(res, 9'h008);
    drv_val[3] = 1'b0;
    cyc(4);
    chk(res, 9'h000);
    bus(1'b1, 1'b1, 16'hff91, 8'hff);
    bus(1'b1, 1'b0, 16'hff91, 8'h00);
    chk(rd, 9'h077);
  endtask

  // routes on the other slots, plus a routing write read back on the next cycle
  task automatic t_slots();
    bus(1'b1, 1'b1, 16'hff91, 8'h60);
    bus(1'b0, 1'b1, 8'h90, 8'h01);
    bus(1'b1, 1'b1, 16'hff90, 8'h02);
    bus(1'b1, 1'b1, 16'hff92, 8'h05);
    drv_val[4:2] = 3'b100;
    cyc(4);
    chk(res, 9'h00b);
    @(posedge clk);
    #1;
    xram_addr = 16'hff93;
    bus_wdata = 8'h5a;
    xram_we = 1'b1;
    @(posedge clk);
    #1;
    xram_we = 1'b0;
    xram_re = 1'b1;
    @(posedge clk);
    #1;
    xram_re = 1'b0;
    chk({1'b0, bus_rdata}, 9'h052);
  endtask

  task automatic t_timer_ctrl();
    bus(1'b0, 1'b1, 8'h88, 8'hff);
    chk(irq_type, 9'h003);
    bus(1'b0, 1'b0, 8'h88, 8'h00);
    chk(rd, 9'h005);
    bus(1'b0, 1'b1, 8'h88, 8'h04);
    chk(irq_type, 9'h002);
    bus(1'b0, 1'b0, 8'h92, 8'h00);
    chk(rd, 9'h000);
  endtask

  task automatic final_report();
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // reset held for twelve cycles, then the scenarios in turn
  initial begin
    rstn = 1'b0;
    {sfr_addr, sfr_we, sfr_re, xram_addr, xram_we, xram_re, bus_wdata} = '0;
    drv_en = 9'h000;
    drv_val = 9'h000;
    fail_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_direction();
    t_route();
    t_slots();
    t_timer_ctrl();
    final_report();
  end

  // the scenarios need well under a thousand cycles
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
endmodule

// >>> upp_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for the pin levels
module upp_sync #(
  parameter int unsigned W = 9
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // reset to ones: pins float high on their pull-ups at start
  always_comb begin
    meta_next = d;
    q_next = meta_reg;
    if (!rstn) begin
      meta_next = '1;
      q_next = '1;
    end
  end

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    q_reg <= q_next;
  end

  assign q = q_reg;
endmodule
